// File: core/counter_bank.sv
// bank of wrapping 32-bit event counters with indexed read
`timescale 1ns/1ps
module counter_bank (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // counters
  stats_if.bank     port
);

  logic [hippi_stats_pkg::CNT_W-1:0] cnt_reg [hippi_stats_pkg::NUM_CNT];

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < hippi_stats_pkg::NUM_CNT; i++) begin : g_cnt
    logic                              bump;
    logic [hippi_stats_pkg::CNT_W-1:0] cnt_next;
    assign bump = port.event_hit[i] & port.count_enable;
    // an event in the clearing cycle survives as a count of one
    assign cnt_next = port.clear_all ?
                      hippi_stats_pkg::CNT_W'(bump) :
                      cnt_reg[i] + hippi_stats_pkg::CNT_W'(bump);
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        cnt_reg[i] <= '0;
      end else begin
        cnt_reg[i] <= cnt_next;
      end
    end
  end

  // plain mux, reading never disturbs a counter
  assign port.read_count =
    (port.read_index < hippi_stats_pkg::IDX_W'(hippi_stats_pkg::NUM_CNT)) ?
    cnt_reg[port.read_index] : '0;

endmodule : counter_bank

// File: core/hippi_serial_link_error_counters.sv
// link statistics: source and destination error and byte counters
// ----------------------------------------------------------------
// Behaviour
// - count source connection attempts that timed out
// - count source connections dropped by remote
// - count local source parity faults sent out
// - sent byte total kept as two words
// - received byte total kept as two words
// - discard and count unknown protocol packets
// - drop and count connections on LLRC failure
// - drop and count connections on parity error
// - count framing errors and illegal handshake transitions
// - count flag sync losses during packet
// - count packets holding an illegal burst size
// - abort and count packets on sync loss
// - count connections closed without any packet
// - count bursts arriving without an issued ready
// - count packets started badly or too short
// - status shows alternating flag lock
// - status shows framing bit lock
// - status shows optical signal presence
// ----------------------------------------------------------------
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module hippi_serial_link_error_counters (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // source side events
  input  wire logic        src_connect_timeout,
  input  wire logic        src_remote_drop,
  input  wire logic        src_parity_fault,
  input  wire logic        src_word_sent,
  // destination handshake levels and datapath events
  input  wire logic        dst_request,
  input  wire logic        dst_packet,
  input  wire logic        dst_burst,
  input  wire logic        dst_ready_sent,
  input  wire logic        dst_word_valid,
  input  wire logic        dst_ulp_unknown,
  input  wire logic        dst_le_drop,
  input  wire logic        dst_llrc_fail,
  input  wire logic        dst_parity_fail,
  input  wire logic        dst_framing_error,
  // receiver lock pins
  input  wire logic        flag_locked_pin,
  input  wire logic        framing_bit_locked_pin,
  input  wire logic        link_operational_pin,
  input  wire logic        optical_signal_present_pin,
  // actions towards the receive path
  output logic             dst_discard_packet,
  output logic             dst_drop_connection,
  output logic             dst_abort_packet
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] lock_sync;
  logic [2:0] lock_q_reg;
  logic       flag_locked;
  logic       framing_bit_locked;
  logic       link_operational;
  logic       optical_signal_present;

  level_sync #(.WIDTH(4)) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in ({optical_signal_present_pin, link_operational_pin,
                framing_bit_locked_pin, flag_locked_pin}),
    .sync_out (lock_sync)
  );

  assign flag_locked            = lock_sync[0];
  assign framing_bit_locked     = lock_sync[1];
  assign link_operational       = lock_sync[2];
  assign optical_signal_present = lock_sync[3];

  // ----------------------------------------------------------------
  // handshake edges and connection state
  // ----------------------------------------------------------------
  logic request_q_reg;
  logic packet_q_reg;
  logic burst_q_reg;
  logic req_rise;
  logic req_fall;
  logic pkt_rise;
  logic pkt_fall;
  logic burst_rise;
  logic burst_fall;
  hippi_stats_pkg::conn_state_e state_reg;
  hippi_stats_pkg::conn_state_e state_next;

  assign req_rise   = dst_request & ~request_q_reg;
  assign req_fall   = ~dst_request & request_q_reg;
  assign pkt_rise   = dst_packet & ~packet_q_reg;
  assign pkt_fall   = ~dst_packet & packet_q_reg;
  assign burst_rise = dst_burst & ~burst_q_reg;
  assign burst_fall = ~dst_burst & burst_q_reg;

  always_comb begin
    case (state_reg)
      hippi_stats_pkg::CONN_IDLE:
        state_next = dst_request ? hippi_stats_pkg::CONN_OPEN
                                 : hippi_stats_pkg::CONN_IDLE;
      hippi_stats_pkg::CONN_OPEN:
        state_next = !dst_request ? hippi_stats_pkg::CONN_IDLE :
                     dst_packet   ? hippi_stats_pkg::IN_PACKET :
                                    hippi_stats_pkg::CONN_OPEN;
      hippi_stats_pkg::IN_PACKET:
        state_next = !dst_request ? hippi_stats_pkg::CONN_IDLE :
                     !dst_packet  ? hippi_stats_pkg::CONN_OPEN :
                     dst_burst    ? hippi_stats_pkg::IN_BURST  :
                                    hippi_stats_pkg::IN_PACKET;
      hippi_stats_pkg::IN_BURST:
        state_next = !dst_request ? hippi_stats_pkg::CONN_IDLE :
                     !dst_packet  ? hippi_stats_pkg::CONN_OPEN :
                     !dst_burst   ? hippi_stats_pkg::IN_PACKET :
                                    hippi_stats_pkg::IN_BURST;
      default:
        state_next = hippi_stats_pkg::CONN_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg     <= hippi_stats_pkg::CONN_IDLE;
      request_q_reg <= 1'b0;
      packet_q_reg  <= 1'b0;
      burst_q_reg   <= 1'b0;
      lock_q_reg    <= 3'h0;
    end else begin
      state_reg     <= state_next;
      request_q_reg <= dst_request;
      packet_q_reg  <= dst_packet;
      burst_q_reg   <= dst_burst;
      lock_q_reg    <= lock_sync[2:0];
    end
  end

  // ----------------------------------------------------------------
  // destination error detection
  // ----------------------------------------------------------------
  logic frame_state_hit;
  logic flag_lost_hit;
  logic sync_lost;
  logic abort_hit;
  logic null_conn_hit;
  logic ready_err_hit;
  logic bad_start_hit;
  logic ill_burst_hit;
  logic burst_short;
  logic burst_overrun;
  logic [hippi_stats_pkg::CRED_W-1:0] credit_reg;
  logic [hippi_stats_pkg::CRED_W-1:0] credit_next;
  logic [hippi_stats_pkg::WCNT_W-1:0] words_reg;
  logic [hippi_stats_pkg::WCNT_W-1:0] words_next;
  logic pkt_seen_reg;
  logic burst_seen_reg;
  logic first_ok_reg;
  logic short_mid_reg;
  logic illegal_reg;
  logic aborted_reg;

  // framing errors only matter inside a packet
  assign frame_state_hit = (dst_framing_error & dst_packet)
                         | (pkt_rise & ~dst_request)
                         | (burst_rise & ~dst_request)
                         | (burst_rise & dst_request & ~dst_packet)
                         | (req_rise & burst_q_reg)
                         | (req_fall & burst_q_reg);
  assign flag_lost_hit = dst_packet & lock_q_reg[0] & ~flag_locked;
  assign sync_lost = dst_packet & (|(lock_q_reg[2:0] & ~lock_sync[2:0]));
  assign abort_hit = sync_lost & ~aborted_reg;
  assign null_conn_hit = req_fall & ~pkt_seen_reg & ~pkt_rise;

  // credits: one per ready issued, one spent per burst
  assign ready_err_hit = burst_rise & (credit_reg == '0);
  assign credit_next = credit_reg
                     + hippi_stats_pkg::CRED_W'(dst_ready_sent)
                     - hippi_stats_pkg::CRED_W'(burst_rise & ~ready_err_hit);

  // words of the current burst
  assign words_next = burst_rise ? '0 :
                      (dst_burst & dst_word_valid) ? words_reg + 9'h001
                                                   : words_reg;
  assign burst_overrun = dst_burst & dst_word_valid &
                         (words_reg == hippi_stats_pkg::BURST_MAX_WORDS);
  assign burst_short = burst_fall &
                       (words_reg != hippi_stats_pkg::BURST_MAX_WORDS);
  // a short burst is legal only first or last in its packet
  assign ill_burst_hit = pkt_fall &
                         (illegal_reg | burst_overrun |
                          (short_mid_reg & burst_rise));
  assign bad_start_hit = pkt_fall &
                         (~burst_seen_reg | ~first_ok_reg);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      credit_reg     <= '0;
      words_reg      <= '0;
      pkt_seen_reg   <= 1'b0;
      burst_seen_reg <= 1'b0;
      first_ok_reg   <= 1'b0;
      short_mid_reg  <= 1'b0;
      illegal_reg    <= 1'b0;
      aborted_reg    <= 1'b0;
    end else begin
      credit_reg <= req_fall ? '0 : credit_next;
      words_reg  <= words_next;
      // a packet raised with its request still marks the connection
      if (pkt_rise) begin
        pkt_seen_reg <= 1'b1;
      end else if (req_rise) begin
        pkt_seen_reg <= 1'b0;
      end
      if (pkt_rise) begin
        burst_seen_reg <= 1'b0;
        first_ok_reg   <= 1'b0;
        short_mid_reg  <= 1'b0;
        illegal_reg    <= 1'b0;
        // a loss on the opening edge already aborts the new packet
        aborted_reg    <= sync_lost;
      end else begin
        if (burst_fall) begin
          burst_seen_reg <= 1'b1;
        end
        if (dst_burst & dst_word_valid & ~burst_seen_reg &
            (words_next >= hippi_stats_pkg::FIRST_BURST_MIN_WORDS)) begin
          first_ok_reg <= 1'b1;
        end
        if (burst_short & burst_seen_reg) begin
          short_mid_reg <= 1'b1;
        end
        if (burst_overrun | (short_mid_reg & burst_rise)) begin
          illegal_reg <= 1'b1;
        end
        if (sync_lost) begin
          aborted_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // byte totals
  // ----------------------------------------------------------------
  logic [63:0] src_bytes_reg;
  logic [63:0] dst_bytes_reg;
  logic [31:0] src_upper_hold_reg;
  logic [31:0] dst_upper_hold_reg;
  logic        count_enable_reg;
  logic        clear_all_reg;

  // one 64-bit add, so the carry lands in both words at once
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      src_bytes_reg <= '0;
      dst_bytes_reg <= '0;
    end else begin
      if (clear_all_reg) begin
        // a word in the clearing cycle still counts, as in the bank
        src_bytes_reg <= (count_enable_reg & src_word_sent) ?
                         hippi_stats_pkg::BYTES_PER_WORD : '0;
        dst_bytes_reg <= (count_enable_reg & dst_word_valid) ?
                         hippi_stats_pkg::BYTES_PER_WORD : '0;
      end else if (count_enable_reg) begin
        if (src_word_sent) begin
          src_bytes_reg <= src_bytes_reg
                         + hippi_stats_pkg::BYTES_PER_WORD;
        end
        if (dst_word_valid) begin
          dst_bytes_reg <= dst_bytes_reg
                         + hippi_stats_pkg::BYTES_PER_WORD;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // counter bank
  // ----------------------------------------------------------------
  stats_if cnt_port ();

  assign cnt_port.count_enable = count_enable_reg;
  assign cnt_port.clear_all    = clear_all_reg;
  assign cnt_port.read_index   = reg_addr[5:2];
  assign cnt_port.event_hit = {
    bad_start_hit,
    ready_err_hit,
    null_conn_hit,
    abort_hit,
    ill_burst_hit,
    flag_lost_hit,
    frame_state_hit,
    dst_parity_fail & dst_request,
    dst_llrc_fail & dst_request,
    dst_le_drop,
    dst_ulp_unknown,
    src_parity_fault,
    src_remote_drop,
    src_connect_timeout
  };

  counter_bank u_bank (
    .clock   (clock),
    .reset_n (reset_n),
    .port    (cnt_port.bank)
  );

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic        hit_cnt;
  logic        hit_src_upper;
  logic        hit_src_lower;
  logic        hit_dst_upper;
  logic        hit_dst_lower;
  logic        hit_status;
  logic        hit_control;
  logic [31:0] status_word;
  logic [31:0] control_word;
  logic [31:0] rdata_next;

  assign hit_cnt       = (reg_addr < hippi_stats_pkg::OFS_CNT_LIMIT)
                       & (reg_addr[1:0] == 2'h0);
  assign hit_src_upper = reg_addr == hippi_stats_pkg::OFS_SRC_UPPER;
  assign hit_src_lower = reg_addr == hippi_stats_pkg::OFS_SRC_LOWER;
  assign hit_dst_upper = reg_addr == hippi_stats_pkg::OFS_DST_UPPER;
  assign hit_dst_lower = reg_addr == hippi_stats_pkg::OFS_DST_LOWER;
  assign hit_status    = reg_addr == hippi_stats_pkg::OFS_STATUS;
  assign hit_control   = reg_addr == hippi_stats_pkg::OFS_CONTROL;

  always_comb begin
    status_word = 32'h0;
    status_word[hippi_stats_pkg::ST_LINK_OP]   = link_operational;
    status_word[hippi_stats_pkg::ST_FLAG_SYNC] = flag_locked;
    status_word[hippi_stats_pkg::ST_FRAME_BIT] = framing_bit_locked;
    status_word[hippi_stats_pkg::ST_OPTICAL]   =
      optical_signal_present;
    control_word = 32'h0;
    control_word[hippi_stats_pkg::CTL_ENABLE] = count_enable_reg;
  end

  always_comb begin
    if (hit_cnt) begin
      rdata_next = cnt_port.read_count;
    end else if (hit_src_upper) begin
      rdata_next = src_upper_hold_reg;
    end else if (hit_src_lower) begin
      rdata_next = src_bytes_reg[31:0];
    end else if (hit_dst_upper) begin
      rdata_next = dst_upper_hold_reg;
    end else if (hit_dst_lower) begin
      rdata_next = dst_bytes_reg[31:0];
    end else if (hit_status) begin
      rdata_next = status_word;
    end else if (hit_control) begin
      rdata_next = control_word;
    end else begin
      rdata_next = 32'h0;
    end
  end

  // reading a lower word freezes its upper word for the next read
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata          <= 32'h0;
      src_upper_hold_reg <= 32'h0;
      dst_upper_hold_reg <= 32'h0;
      count_enable_reg   <= hippi_stats_pkg::CTL_ENABLE_RST;
      clear_all_reg      <= 1'b0;
    end else begin
      reg_rdata     <= reg_read ? rdata_next : 32'h0;
      clear_all_reg <= reg_write & hit_control &
                       reg_wdata[hippi_stats_pkg::CTL_CLEAR];
      if (reg_write & hit_control) begin
        count_enable_reg <= reg_wdata[hippi_stats_pkg::CTL_ENABLE];
      end
      if (reg_read & hit_src_lower) begin
        src_upper_hold_reg <= src_bytes_reg[63:32];
      end
      if (reg_read & hit_dst_lower) begin
        dst_upper_hold_reg <= dst_bytes_reg[63:32];
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path actions
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dst_discard_packet  <= 1'b0;
      dst_drop_connection <= 1'b0;
      dst_abort_packet    <= 1'b0;
    end else begin
      dst_discard_packet  <= dst_ulp_unknown;
      dst_drop_connection <= dst_request &
                             (dst_llrc_fail | dst_parity_fail);
      dst_abort_packet    <= abort_hit;
    end
  end

endmodule : hippi_serial_link_error_counters

// File: core/level_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : level_sync

// File: shared/hippi_stats_pkg.sv
// constants, register map and types for the link statistics block
package hippi_stats_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W   = 32;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int NUM_CNT = 14;
  localparam int IDX_W   = 4;
  localparam int CRED_W  = 8;
  localparam int WCNT_W  = 9;

  // ----------------------------------------------------------------
  // counter indices, counter i sits at byte address 4*i
  // ----------------------------------------------------------------
  localparam int CNT_SRC_TIMEOUT  = 0;
  localparam int CNT_SRC_RDROP    = 1;
  localparam int CNT_SRC_PARITY   = 2;
  localparam int CNT_BAD_ULP      = 3;
  localparam int CNT_LE_DROP      = 4;
  localparam int CNT_LLRC_DROP    = 5;
  localparam int CNT_PARITY_DROP  = 6;
  localparam int CNT_FRAME_STATE  = 7;
  localparam int CNT_FLAG_LOST    = 8;
  localparam int CNT_ILL_BURST    = 9;
  localparam int CNT_PKT_ABORT    = 10;
  localparam int CNT_NULL_CONN    = 11;
  localparam int CNT_READY_ERR    = 12;
  localparam int CNT_BAD_START    = 13;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CNT_LIMIT = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_SRC_UPPER = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_SRC_LOWER = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_DST_UPPER = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_DST_LOWER = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h54;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int ST_LINK_OP   = 16;
  localparam int ST_FLAG_SYNC = 17;
  localparam int ST_FRAME_BIT = 18;
  localparam int ST_OPTICAL   = 19;
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_CLEAR    = 1;
  localparam logic CTL_ENABLE_RST = 1'b1;

  // ----------------------------------------------------------------
  // link figures
  // ----------------------------------------------------------------
  localparam logic [WCNT_W-1:0] BURST_MAX_WORDS = 9'h100;
  localparam int WORD_BYTES            = 4;
  localparam int FIRST_BURST_MIN_BYTES = 12;
  localparam logic [WCNT_W-1:0] FIRST_BURST_MIN_WORDS =
    WCNT_W'((FIRST_BURST_MIN_BYTES + WORD_BYTES - 1) / WORD_BYTES);
  localparam logic [2*CNT_W-1:0] BYTES_PER_WORD = 64'h4;

  // receive side connection state, gray along idle-open-packet-burst
  typedef enum logic [1:0] {
    CONN_IDLE = 2'b00,
    CONN_OPEN = 2'b01,
    IN_PACKET = 2'b11,
    IN_BURST  = 2'b10
  } conn_state_e;

endpackage : hippi_stats_pkg

// File: shared/stats_if.sv
// bundle between the statistics top and its counter bank
`timescale 1ns/1ps
interface stats_if;
  logic [hippi_stats_pkg::NUM_CNT-1:0] event_hit;
  logic                                count_enable;
  logic                                clear_all;
  logic [hippi_stats_pkg::IDX_W-1:0]   read_index;
  logic [hippi_stats_pkg::CNT_W-1:0]   read_count;

  modport bank (
    input  event_hit,
    input  count_enable,
    input  clear_all,
    input  read_index,
    output read_count
  );
  modport user (
    output event_hit,
    output count_enable,
    output clear_all,
    output read_index,
    input  read_count
  );
endinterface : stats_if

// File: testbench/remote_source_model.sv
// remote link node driving the destination handshake
`timescale 1ns/1ps
module remote_source_model (
  // clock
  input  wire logic clock,
  // handshake levels and pulses toward the destination
  output logic      request = 1'b0,
  output logic      packet = 1'b0,
  output logic      burst = 1'b0,
  output logic      ready_sent = 1'b0,
  output logic      word_valid = 1'b0,
  output logic      flag_locked = 1'b1
);
  // r=0 sends the burst without credit, l=1 loses flag lock mid packet
  task automatic conn(input bit p, input int w, input bit r, input bit l);
    @(posedge clock) request <= 1'b1;
    @(posedge clock) ready_sent <= r;
    @(posedge clock) ready_sent <= 1'b0;
    packet <= p;
    if (w > 0) begin
      @(posedge clock) burst <= 1'b1;
      repeat (w) @(posedge clock) word_valid <= 1'b1;
      @(posedge clock) word_valid <= 1'b0;
      burst <= 1'b0;
    end
    @(posedge clock) flag_locked <= !l;
    repeat (4) @(posedge clock);
    packet <= 1'b0;
    @(posedge clock) request <= 1'b0;
    flag_locked <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : conn
endmodule : remote_source_model

// File: testbench/stats_assertions.sv
// port checks for the link statistics block
`timescale 1ns/1ps
module stats_assertions (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // destination side
  input wire logic        dst_request,
  input wire logic        dst_packet,
  input wire logic        dst_ulp_unknown,
  input wire logic        dst_llrc_fail,
  input wire logic        dst_parity_fail,
  input wire logic        dst_discard_packet,
  input wire logic        dst_drop_connection,
  input wire logic        dst_abort_packet
);
  logic fail_in;
  assign fail_in = (dst_llrc_fail || dst_parity_fail) && dst_request;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  discard_late_a:
    assert property (dst_ulp_unknown |=> dst_discard_packet)
      else $error("discard missing");
  discard_cause_a:
    assert property (dst_discard_packet |-> $past(dst_ulp_unknown))
      else $error("discard uncaused");
  drop_late_a:
    assert property (fail_in |=> dst_drop_connection)
      else $error("drop missing");
  drop_cause_a:
    assert property (dst_drop_connection |-> $past(fail_in))
      else $error("drop uncaused");
  abort_once_a:
    assert property (dst_abort_packet |=> !dst_abort_packet)
      else $error("abort repeated");
  abort_cause_a:
    assert property (dst_abort_packet |-> $past(dst_packet))
      else $error("abort outside packet");
  rdata_idle_a:
    assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data not idle");
  unmapped_zero_a:
    assert property (reg_read && reg_addr == 8'hfc |=> reg_rdata == 32'h0)
      else $error("unmapped read");
  cover property (dst_discard_packet);
  cover property (dst_drop_connection);
  cover property (dst_abort_packet);
endmodule : stats_assertions
bind hippi_serial_link_error_counters stats_assertions chk (.*);

// File: testbench/tb_hippi_serial_link_error_counters.sv
// self-checking bench for the link statistics block
`timescale 1ns/1ps
module tb_hippi_serial_link_error_counters;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        rd_d = 1'b0;
  logic [31:0] reg_rdata;
  logic [8:0]  ev = 9'h0;
  logic [2:0]  pins = 3'h7;
  logic        rq = 1'b0;
  logic        pk = 1'b0;
  logic        m_rq, m_pk, burst, rdy, word, flag;
  logic [31:0] exp_c [14];
  logic [63:0] src_b, dst_b;
  logic [39:0] exp_q [$];
  int          errors = 0;
  int          checks_done = 0;
  always #2 clock = ~clock;
  hippi_serial_link_error_counters dut (.*,
    .src_connect_timeout(ev[0]), .src_remote_drop(ev[1]),
    .src_parity_fault(ev[2]), .src_word_sent(ev[3]),
    .dst_request(rq | m_rq), .dst_packet(pk | m_pk), .dst_burst(burst),
    .dst_ready_sent(rdy), .dst_word_valid(word),
    .dst_ulp_unknown(ev[4]), .dst_le_drop(ev[5]), .dst_llrc_fail(ev[6]),
    .dst_parity_fail(ev[7]), .dst_framing_error(ev[8]),
    .flag_locked_pin(flag), .framing_bit_locked_pin(pins[0]),
    .link_operational_pin(pins[1]), .optical_signal_present_pin(pins[2]),
    .dst_discard_packet(), .dst_drop_connection(), .dst_abort_packet());
  remote_source_model rem (.clock(clock), .request(m_rq), .packet(m_pk),
    .burst(burst), .ready_sent(rdy), .word_valid(word), .flag_locked(flag));
  // ----------------------------------------------------------------
  // register and event drivers
  // ----------------------------------------------------------------
  // read strobe is left high so reads run back to back
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    exp_q.push_back({a, v});
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
  endtask : rd
  task automatic wr(input logic [31:0] v);
    reg_read <= 1'b0;
    reg_write <= 1'b1;
    reg_addr <= 8'h54;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      ev[i] <= 1'b1;
      @(posedge clock);
    end
    ev[i] <= 1'b0;
    @(posedge clock);
  endtask : pulse
  // lower word first, its read snapshots the upper word
  task automatic sweep();
    for (int i = 0; i < 14; i++) rd(8'(4 * i), exp_c[i]);
    rd(8'h44, src_b[31:0]);
    rd(8'h40, src_b[63:32]);
    rd(8'h4c, dst_b[31:0]);
    rd(8'h48, dst_b[63:32]);
    rd(8'hfc, 32'h0);
    rd(8'h54, 32'h1);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask : sweep
  task automatic end_sim();
    if (exp_q.size() != 0) errors++;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    if (rd_d && exp_q.size() > 0) begin
      checks_done++;
      if (reg_rdata !== exp_q[0][31:0]) begin
        errors++;
        $display("[FAIL] reg %h exp %h got %h", exp_q[0][39:32],
                 exp_q[0][31:0], reg_rdata);
      end
      void'(exp_q.pop_front());
    end
    rd_d <= reg_read;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_sim();
  end
  initial begin
    int n;
    n = $urandom(32'h005ecb8b);
    foreach (exp_c[i]) exp_c[i] = 32'h0;
    src_b = 64'h0;
    dst_b = 64'h0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    sweep();
    rq <= 1'b1;
    @(posedge clock);
    pk <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      n = $urandom_range(1, 4);
      pulse(i, n);
      if (i == 3) src_b += 64'(4 * n);
      else exp_c[i < 3 ? i : i - 1] += 32'(n);
    end
    pk <= 1'b0;
    @(posedge clock);
    rq <= 1'b0;
    wr(32'h0);
    pulse(0, 2);
    wr(32'h1);
    rem.conn(1'b1, 3, 1'b1, 1'b0);
    rem.conn(1'b0, 0, 1'b0, 1'b0);
    rem.conn(1'b1, 3, 1'b0, 1'b0);
    rem.conn(1'b1, 257, 1'b1, 1'b0);
    rem.conn(1'b1, 2, 1'b1, 1'b0);
    rem.conn(1'b1, 3, 1'b1, 1'b1);
    dst_b += 64'(4 * 268);
    exp_c[8]++;
    exp_c[9]++;
    exp_c[10]++;
    exp_c[11]++;
    exp_c[12]++;
    exp_c[13] += 32'h2;
    sweep();
    pins <= 3'($urandom);
    repeat (4) @(posedge clock);
    rd(8'h50, {12'h0, pins[2], pins[0], 1'b1, pins[1], 16'h0});
    wr(32'h3);
    foreach (exp_c[i]) exp_c[i] = 32'h0;
    src_b = 64'h0;
    dst_b = 64'h0;
    sweep();
    repeat (3) @(posedge clock);
    end_sim();
  end
endmodule : tb_hippi_serial_link_error_counters
